// ===== hw/nc_pkg.sv
// Purpose: shared constants and types for the host command interpreter.
// Assumes: function and status codes are written in hex; their octal names sit beside them.
// Notes: register offsets are even byte addresses of 16-bit registers on the plain register port.
package nc_pkg;
  // ==========================================================
  // register map
  localparam logic [2:0] REG_BUF_ADDR = 3'h0;
  localparam logic [2:0] REG_BYTE_COUNT = 3'h2;
  localparam logic [2:0] REG_CTRL_STATUS = 3'h4;
  localparam logic [2:0] REG_TX_LEVEL = 3'h6;
  localparam int CMD_LSB = 8;
  localparam int FN_W = 6;
  // ==========================================================
  // function codes (octal 31, 32, 33-37, 40, 41-47, 50, 51)
  localparam logic [5:0] FN_COLL_REPORT = 6'h19;
  localparam logic [5:0] FN_MAINT = 6'h1A;
  localparam logic [5:0] FN_ILL_LO = 6'h1B;
  localparam logic [5:0] FN_ILL_HI = 6'h1F;
  localparam logic [5:0] FN_RXQ_SUPPLY = 6'h20;
  localparam logic [5:0] FN_RSV_LO = 6'h21;
  localparam logic [5:0] FN_RSV_HI = 6'h27;
  localparam logic [5:0] FN_TX_LOAD = 6'h28;
  localparam logic [5:0] FN_TX_SEND = 6'h29;
  // ==========================================================
  // completion status (octal 00, 02, 05, 17)
  localparam logic [3:0] ST_OK = 4'h0;
  localparam logic [3:0] ST_ILLEGAL = 4'h2;
  localparam logic [3:0] ST_SIZE = 4'h5;
  localparam logic [3:0] ST_NXM = 4'hF;
  // ==========================================================
  // limits and layouts
  localparam logic [16:0] TX_LIMIT = 17'h005E4;
  localparam logic [15:0] MAINT_MAX = 16'h0800;
  localparam logic [4:0] RXQ_FULL = 5'h10;
  localparam int RXQ_DEPTH = 16;
  localparam int RXQ_ENTRY_W = 34;
  localparam int COLL_DEPTH = 16;
  localparam logic [15:0] COLL_RES_MASK = 16'hFFF8;
  localparam logic [2:0] CHAIN_ALIGN_MASK = 3'h7;
  localparam logic [15:0] COLL_LEN_MAX = 16'h0020;
  localparam int BIT_TIME_NS = 100;
  localparam logic [17:0] WORD_STEP = 18'h00002;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  // ==========================================================
  // sequencer states
  typedef enum logic [3:0] {
    S_IDLE, S_COLL, S_MAINT, S_PROBE, S_TX,
    S_RX_POP, S_RX_HDR, S_RX_LEN, S_RX_DATA, S_RX_DROP
  } nc_state_t;
endpackage

// ===== hw/nc_mem.sv
// Purpose: small synchronous memory with one write and one registered read port.
// Assumes: single clock; read returns the old word when read and write meet.
// Notes: contents are undefined until written.
`timescale 1ns/10ps
module nc_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic clk,
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [WIDTH-1:0] wrData,
  input wire logic [AW-1:0] rdAddr,
  output logic [WIDTH-1:0] rdData
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule

// ===== hw/nc_bitrev.sv
// Purpose: reverses the bit order of a word.
// Assumes: purely combinational.
// Notes: used on check-sequence words of received frames.
`timescale 1ns/10ps
module nc_bitrev #(
  parameter int WIDTH = 16
) (
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  always_comb begin
    dout = din;
    for (int i = 0; i < WIDTH; i++) begin
      dout[i] = din[WIDTH-1-i];
    end
  end
endmodule

// ===== hw/nc_host_cmd.sv
// Purpose: host command interpreter and word DMA engine, function codes 31 to 51 (octal).
// Assumes: host memory port, receive stream and transmit fifo all run on clk.
// Notes: all state but the queue and delay memories lives in one packed struct registered once per clock.
// Notes on behaviour
// - collision report ends with status 00, or 17 on a memory fault.
// - report starts with a length word of twice the collision count, 0 to 32.
// - each delay entry counts bit times at 8-bit resolution, 100 ns each.
// - code 32 writes up to 2048 bytes to the buffer; 00 or 17.
// - codes 33 to 37 do nothing and return illegal status 02.
// - codes 41 to 47 also return illegal status 02.
// - code 40 appends address and count to a 16-entry receive queue.
// - a ready received frame pops the oldest queue entry and is written there.
// - supply receive buffer returns 00, 05 if the queue is full, or 17 if its first word faults.
// - a short buffer whose count is a multiple of 8 chains into the next.
// - frame status byte: bits 7-3 zero, bit 2 lost, 1 alignment, 0 crc.
// - frame length word counts header, data and crc, not the pad byte.
// - odd frames carry one undefined filler byte beyond the counted length.
// - delivered check sequence has its bits in reversed order.
// - data field of 46 to 1500 bytes follows addresses and type.
// - a frame lost to a full fifo sets the lost flag of the next frame.
// - code 50 loads host data into the transmit fifo without sending.
// - loading returns 05 when fifo bytes plus buffer bytes exceed 1508.
// - successful load returns 00; a memory fault aborts with 17.
// - code 51 loads the buffer and then sends the whole frame.
`timescale 1ns/10ps
module nc_host_cmd
  import nc_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [2:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdata,
  output logic dmaReq,
  output logic dmaWe,
  output logic [17:0] dmaAddr,
  output logic [15:0] dmaWdata,
  input wire logic [15:0] dmaRdata,
  input wire logic dmaAck,
  input wire logic dmaNxm,
  input wire logic [4:0] collCount,
  input wire logic collWr,
  input wire logic [3:0] collIdx,
  input wire logic [15:0] collBits,
  input wire logic rxValid,
  input wire logic [15:0] rxData,
  input wire logic rxLast,
  input wire logic rxCrcWord,
  input wire logic [10:0] rxLen,
  input wire logic rxCrcErr,
  input wire logic rxAlignErr,
  input wire logic rxLost,
  output logic rxTake,
  output logic txValid,
  output logic [15:0] txData,
  output logic txSend,
  output logic txPurge
);
  // ==========================================================
  // state
  typedef struct packed {
    nc_state_t st;
    logic [15:0] bar;
    logic [15:0] byte_count_reg;
    logic [7:0] cmd;
    logic busy;
    logic done;
    logic [3:0] status;
    logic [15:0] rdata;
    logic dmaReq;
    logic dmaWe;
    logic [17:0] dmaAddr;
    logic [15:0] dmaWdata;
    logic [17:0] ptr;
    logic [15:0] rem;
    logic [4:0] idx;
    logic [3:0] qHead;
    logic [3:0] qTail;
    logic [4:0] qCount;
    logic [11:0] txLevel;
    logic txValid;
    logic [15:0] txData;
    logic txSend;
    logic txPurge;
    logic rxTake;
    logic lostPend;
    logic chainOk;
    logic lastSeen;
    logic hdrDone;
  } nc_core_t;

  nc_core_t s;
  nc_core_t n;
  logic dmaFin;
  logic fin;
  logic [3:0] finCode;
  logic dmaGo;
  logic goWe;
  logic [15:0] goData;
  logic [5:0] fn;
  logic [16:0] txSum;
  logic qWr;
  logic [RXQ_ENTRY_W-1:0] qRd;
  logic [15:0] collRd;
  logic [15:0] rxRev;

  function automatic logic [15:0] remDec(input logic [15:0] r);
    remDec = (r < 16'h0002) ? 16'h0000 : r - 16'h0002;
  endfunction

  // ==========================================================
  // receive queue and collision delay store
  assign qWr = (s.st == S_PROBE) && dmaFin && !dmaNxm;

  nc_mem #(.WIDTH(RXQ_ENTRY_W), .DEPTH(RXQ_DEPTH)) rxQueue (
    .clk(clk),
    .wrEn(qWr),
    .wrAddr(s.qTail),
    .wrData({s.ptr, s.byte_count_reg}),
    .rdAddr(n.qHead),
    .rdData(qRd)
  );

  nc_mem #(.WIDTH(16), .DEPTH(COLL_DEPTH)) collStore (
    .clk(clk),
    .wrEn(collWr),
    .wrAddr(collIdx),
    .wrData(collBits & COLL_RES_MASK),
    .rdAddr(n.idx[3:0]),
    .rdData(collRd)
  );

  nc_bitrev #(.WIDTH(16)) crcFlip (
    .din(rxData),
    .dout(rxRev)
  );

  assign fn = s.cmd[FN_W-1:0];
  assign txSum = {5'h00, s.txLevel} + {1'b0, s.byte_count_reg};
  assign dmaFin = s.dmaReq && (dmaAck || dmaNxm);

  // ==========================================================
  // next state
  always_comb begin
    n = s;
    fin = 1'b0;
    finCode = ST_OK;
    dmaGo = 1'b0;
    goWe = 1'b1;
    goData = RESET_WORD;
    n.rdata = RESET_WORD;
    n.txValid = 1'b0;
    n.txSend = 1'b0;
    n.txPurge = 1'b0;
    n.rxTake = 1'b0;
    if (dmaFin) begin
      n.dmaReq = 1'b0;
    end
    // register port
    if (regRd) begin
      case (regAddr)
        REG_BUF_ADDR: n.rdata = s.bar;
        REG_BYTE_COUNT: n.rdata = s.byte_count_reg;
        REG_CTRL_STATUS: n.rdata = {s.cmd, s.done, s.busy, 2'b00, s.status};
        REG_TX_LEVEL: n.rdata = {4'h0, s.txLevel};
        default: n.rdata = RESET_WORD;
      endcase
    end
    if (regWr && !s.busy) begin
      case (regAddr)
        REG_BUF_ADDR: n.bar = regWdata;
        REG_BYTE_COUNT: n.byte_count_reg = regWdata;
        REG_CTRL_STATUS: begin
          n.cmd = regWdata[CMD_LSB +: 8];
          n.busy = 1'b1;
          n.done = 1'b0;
        end
        default: n.bar = s.bar;
      endcase
    end
    case (s.st)
      S_IDLE: begin
        if (s.busy) begin
          n.ptr = {s.cmd[7:6], s.bar};
          n.idx = 5'h00;
          if (fn == FN_COLL_REPORT) begin
            n.st = S_COLL;
            dmaGo = 1'b1;
            goData = {10'h000, collCount, 1'b0};
          end else if (fn == FN_MAINT) begin
            n.rem = (s.byte_count_reg > MAINT_MAX) ? MAINT_MAX : s.byte_count_reg;
            n.st = S_MAINT;
          end else if (fn == FN_RXQ_SUPPLY) begin
            if (s.qCount == RXQ_FULL) begin
              fin = 1'b1;
              finCode = ST_SIZE;
            end else begin
              n.st = S_PROBE;
              dmaGo = 1'b1;
              goWe = 1'b0;
            end
          end else if (fn == FN_TX_LOAD || fn == FN_TX_SEND) begin
            if (txSum > TX_LIMIT) begin
              fin = 1'b1;
              finCode = ST_SIZE;
              n.txLevel = 12'h000;
              n.txPurge = 1'b1;
            end else begin
              n.rem = s.byte_count_reg;
              n.st = S_TX;
            end
          end else begin
            fin = 1'b1;
            finCode = ST_ILLEGAL;
          end
        end else if (rxValid && s.qCount != 5'h00 && !s.rxTake) begin
          n.hdrDone = 1'b0;
          n.st = S_RX_POP;
        end
      end
      S_COLL: begin
        if (dmaFin) begin
          if (dmaNxm) begin
            fin = 1'b1;
            finCode = ST_NXM;
          end else begin
            n.ptr = s.ptr + WORD_STEP;
            if (s.idx == collCount) begin
              fin = 1'b1;
              finCode = ST_OK;
            end else begin
              dmaGo = 1'b1;
              goData = collRd;
              n.idx = s.idx + 5'h01;
            end
          end
        end
      end
      S_MAINT: begin
        if (dmaFin) begin
          if (dmaNxm) begin
            fin = 1'b1;
            finCode = ST_NXM;
          end else begin
            n.ptr = s.ptr + WORD_STEP;
            n.rem = remDec(s.rem);
          end
        end else if (!s.dmaReq) begin
          if (s.rem == 16'h0000) begin
            fin = 1'b1;
            finCode = ST_OK;
          end else begin
            dmaGo = 1'b1;
          end
        end
      end
      S_PROBE: begin
        if (dmaFin) begin
          fin = 1'b1;
          finCode = dmaNxm ? ST_NXM : ST_OK;
          if (!dmaNxm) begin
            n.qTail = s.qTail + 4'h1;
            n.qCount = s.qCount + 5'h01;
          end
        end
      end
      S_TX: begin
        if (dmaFin) begin
          if (dmaNxm) begin
            fin = 1'b1;
            finCode = ST_NXM;
          end else begin
            n.txValid = 1'b1;
            n.txData = dmaRdata;
            n.txLevel = s.txLevel + ((s.rem == 16'h0001) ? 12'h001 : 12'h002);
            n.rem = remDec(s.rem);
            n.ptr = s.ptr + WORD_STEP;
          end
        end else if (!s.dmaReq) begin
          if (s.rem == 16'h0000) begin
            fin = 1'b1;
            finCode = ST_OK;
            if (fn == FN_TX_SEND) begin
              n.txSend = 1'b1;
              n.txLevel = 12'h000;
            end
          end else begin
            dmaGo = 1'b1;
            goWe = 1'b0;
          end
        end
      end
      S_RX_POP: begin
        n.ptr = qRd[RXQ_ENTRY_W-1:16];
        n.rem = qRd[15:0];
        n.chainOk = (qRd[2:0] & CHAIN_ALIGN_MASK) == 3'h0;
        n.qHead = s.qHead + 4'h1;
        n.qCount = s.qCount - 5'h01;
        if (!s.hdrDone) begin
          n.st = S_RX_HDR;
          n.lastSeen = 1'b0;
          n.lostPend = 1'b0;
          dmaGo = 1'b1;
          goData = {8'h00, 5'h00, s.lostPend, rxAlignErr, rxCrcErr};
        end else begin
          n.st = S_RX_DATA;
        end
      end
      S_RX_HDR: begin
        if (dmaFin) begin
          n.ptr = s.ptr + WORD_STEP;
          n.rem = remDec(s.rem);
          n.st = dmaNxm ? S_RX_DROP : S_RX_LEN;
          dmaGo = !dmaNxm;
          goData = {5'h00, rxLen};
        end
      end
      S_RX_LEN: begin
        if (dmaFin) begin
          n.ptr = s.ptr + WORD_STEP;
          n.rem = remDec(s.rem);
          n.hdrDone = 1'b1;
          n.st = dmaNxm ? S_RX_DROP : S_RX_DATA;
        end
      end
      S_RX_DATA: begin
        if (dmaFin) begin
          n.ptr = s.ptr + WORD_STEP;
          n.rem = remDec(s.rem);
          if (s.lastSeen) begin
            n.st = S_IDLE;
          end else if (dmaNxm) begin
            n.st = S_RX_DROP;
          end
        end else if (!s.dmaReq && !s.rxTake) begin
          if (s.rem < 16'h0002) begin
            if (!s.chainOk) begin
              n.st = S_RX_DROP;
            end else if (s.qCount != 5'h00) begin
              n.st = S_RX_POP;
            end
          end else if (rxValid) begin
            n.rxTake = 1'b1;
            n.lastSeen = rxLast;
            dmaGo = 1'b1;
            goData = rxCrcWord ? rxRev : rxData;
          end
        end
      end
      S_RX_DROP: begin
        if (rxValid && !s.rxTake) begin
          n.rxTake = 1'b1;
          if (rxLast) begin
            n.st = S_IDLE;
          end
        end
      end
      default: n.st = S_IDLE;
    endcase
    if (rxLost) begin
      n.lostPend = 1'b1;
    end
    if (fin) begin
      n.busy = 1'b0;
      n.done = 1'b1;
      n.status = finCode;
      n.st = S_IDLE;
    end
    if (dmaGo) begin
      n.dmaReq = 1'b1;
      n.dmaWe = goWe;
      n.dmaAddr = n.ptr;
      n.dmaWdata = goData;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // ==========================================================
  // outputs
  assign regRdata = s.rdata;
  assign dmaReq = s.dmaReq;
  assign dmaWe = s.dmaWe;
  assign dmaAddr = s.dmaAddr;
  assign dmaWdata = s.dmaWdata;
  assign rxTake = s.rxTake;
  assign txValid = s.txValid;
  assign txData = s.txData;
  assign txSend = s.txSend;
  assign txPurge = s.txPurge;

  // ==========================================================
  // checks
  coll_len_a: assert property (
    @(posedge clk) disable iff (!rstn)
    s.st == S_IDLE && s.busy && fn == FN_COLL_REPORT
    |=> s.dmaReq && s.dmaWdata <= COLL_LEN_MAX && s.dmaWdata[0] == 1'b0)
    else $error("collision length word out of range");

  coll_res_a: assert property (
    @(posedge clk) disable iff (!rstn)
    s.st == S_COLL && s.dmaReq && s.idx != 5'h00 |-> s.dmaWdata[2:0] == 3'h0)
    else $error("collision entry finer than eight bits");

  maint_cap_a: assert property (
    @(posedge clk) disable iff (!rstn)
    s.st == S_MAINT |-> s.rem <= MAINT_MAX)
    else $error("maintenance transfer exceeds cap");

  illegal_code_a: assert property (
    @(posedge clk) disable iff (!rstn)
    regWr && regAddr == REG_CTRL_STATUS && !s.busy && s.st == S_IDLE && !rxValid
    && regWdata[CMD_LSB +: FN_W] >= FN_ILL_LO && regWdata[CMD_LSB +: FN_W] <= FN_ILL_HI
    |-> ##2 (s.done && !s.busy && s.status == ST_ILLEGAL))
    else $error("reserved code not answered with illegal status");

  queue_depth_a: assert property (
    @(posedge clk) disable iff (!rstn)
    s.qCount <= RXQ_FULL && !(qWr && s.qCount == RXQ_FULL))
    else $error("receive queue overfilled");

  frame_status_a: assert property (
    @(posedge clk) disable iff (!rstn)
    s.st == S_RX_HDR && s.dmaReq |-> s.dmaWdata[15:3] == 13'h0000)
    else $error("frame status upper bits not zero");

  nxm_abort_a: assert property (
    @(posedge clk) disable iff (!rstn)
    dmaFin && dmaNxm && (s.st == S_COLL || s.st == S_TX || s.st == S_PROBE)
    |=> s.done && !s.busy && s.status == ST_NXM && s.st == S_IDLE)
    else $error("memory fault did not abort with status 17");

  tx_size_a: assert property (
    @(posedge clk) disable iff (!rstn)
    s.st == S_IDLE && s.busy && (fn == FN_TX_LOAD || fn == FN_TX_SEND) && txSum > TX_LIMIT
    |=> s.status == ST_SIZE && s.txPurge && s.txLevel == 12'h000 ##1 !s.txPurge)
    else $error("oversize load not refused with status 05");

  send_done_a: assert property (
    @(posedge clk) disable iff (!rstn)
    s.txSend |-> s.done && s.status == ST_OK && $past(s.st) == S_TX && fn == FN_TX_SEND)
    else $error("frame sent without a completed load and send");

  lost_keep_a: assert property (
    @(posedge clk) disable iff (!rstn)
    rxLost |=> s.lostPend)
    else $error("lost frame event dropped");

  done_flag_a: assert property (
    @(posedge clk) disable iff (!rstn)
    $fell(s.busy) |-> s.done && s.st == S_IDLE)
    else $error("command finished without completion flag");
endmodule

// ===== sim/nc_host_mem.sv
// Purpose: host memory model on the word dma port.
// Assumes: one clock; answer latency set by the bench.
// Notes: only bank 5'h08 of the 18-bit space exists; all else faults.
`timescale 1ns/10ps
module nc_host_mem (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [1:0] lat,
  input wire logic dmaReq,
  input wire logic dmaWe,
  input wire logic [17:0] dmaAddr,
  input wire logic [15:0] dmaWdata,
  output logic [15:0] dmaRdata,
  output logic dmaAck,
  output logic dmaNxm
);
  logic [15:0] mem [0:4095];
  logic [1:0] waitCnt;
  // ==========================================
  // answer after lat cycles; data bus toggles when idle
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dmaAck <= 1'b0;
      dmaNxm <= 1'b0;
      dmaRdata <= 16'h5A5A;
      waitCnt <= 2'h0;
    end else begin
      dmaAck <= 1'b0;
      dmaNxm <= 1'b0;
      dmaRdata <= ~dmaRdata;
      if (dmaReq && !dmaAck && !dmaNxm) begin
        if (waitCnt != 2'h0) begin
          waitCnt <= waitCnt - 2'h1;
        end else if (dmaAddr[17:13] != 5'h08) begin
          dmaNxm <= 1'b1;
          waitCnt <= lat;
        end else begin
          dmaAck <= 1'b1;
          waitCnt <= lat;
          if (dmaWe) begin
            mem[dmaAddr[12:1]] <= dmaWdata;
          end else begin
            dmaRdata <= mem[dmaAddr[12:1]];
          end
        end
      end
    end
  end
endmodule

// ===== sim/net_ctrl_host_command_dma_test.sv
// Purpose: self-checking bench for the host command interpreter.
// Assumes: host memory model answers the dma port.
// Notes: buffers live in bank 5'h08, reached with extension bits 01.
`timescale 1ns/10ps
module net_ctrl_host_command_dma_test
  import nc_pkg::*;
;
  logic clk, rstn, regWr, regRd, collWr, rxValid, rxLast, rxCrcWord, rxCrcErr, rxAlignErr;
  logic rxLost, dmaReq, dmaWe, dmaAck, dmaNxm, rxTake, txValid, txSend, txPurge;
  logic [2:0] regAddr;
  logic [15:0] regWdata, regRdata, collBits, rxData, dmaWdata, dmaRdata, txData;
  logic [4:0] collCount;
  logic [3:0] collIdx;
  logic [10:0] rxLen;
  logic [1:0] lat;
  logic [17:0] dmaAddr;
  int nErrors, checkCount, cyc, txSends, txPurges, sendExp, purgeExp, txLevel;
  integer seed = 32'h3708A14B;
  logic [15:0] txExp[$];
  logic [15:0] rxBufs[$];
  localparam logic [15:0] TXB = 16'h0100;

  nc_host_cmd DUT (.clk(clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .dmaReq(dmaReq), .dmaWe(dmaWe),
    .dmaAddr(dmaAddr), .dmaWdata(dmaWdata), .dmaRdata(dmaRdata), .dmaAck(dmaAck),
    .dmaNxm(dmaNxm), .collCount(collCount), .collWr(collWr), .collIdx(collIdx),
    .collBits(collBits), .rxValid(rxValid), .rxData(rxData), .rxLast(rxLast),
    .rxCrcWord(rxCrcWord), .rxLen(rxLen), .rxCrcErr(rxCrcErr), .rxAlignErr(rxAlignErr),
    .rxLost(rxLost), .rxTake(rxTake), .txValid(txValid), .txData(txData),
    .txSend(txSend), .txPurge(txPurge));
  nc_host_mem MEM (.clk(clk), .rstn(rstn), .lat(lat), .dmaReq(dmaReq), .dmaWe(dmaWe),
    .dmaAddr(dmaAddr), .dmaWdata(dmaWdata), .dmaRdata(dmaRdata), .dmaAck(dmaAck),
    .dmaNxm(dmaNxm));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ==========================================
  // checking and bus tasks
  task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
    checkCount++;
    if (got !== exp) begin
      nErrors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task giveVerdict;
    $display("checks %0d mismatches %0d", checkCount, nErrors);
    if (nErrors == 0 && checkCount > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask
  task cmd(input logic [5:0] fn, input logic [1:0] ext, input logic [15:0] a, c,
      output logic [3:0] st);
    logic [15:0] v;
    int n;
    lat <= 2'($random(seed));
    wr(REG_BUF_ADDR, a);
    wr(REG_BYTE_COUNT, c);
    wr(REG_CTRL_STATUS, {ext, fn, 8'h00});
    n = 0;
    v = 16'h0000;
    while (v[7] !== 1'b1 && n < 4000) begin
      rd(REG_CTRL_STATUS, v);
      n++;
    end
    chk("done flag", 18'h1, {17'h0, v[7]});
    chk("command byte", {10'h0, ext, fn}, {10'h0, v[15:8]});
    st = v[3:0];
  endtask
  task txcmd(input logic [5:0] fn, input logic [15:0] c);
    logic [3:0] st, exp;
    logic [15:0] v;
    exp = (txLevel + int'(c) > int'(TX_LIMIT)) ? ST_SIZE : ST_OK;
    if (exp == ST_OK) for (int i = 0; i < c / 2; i++) txExp.push_back(MEM.mem[128 + i]);
    cmd(fn, 2'b01, TXB, c, st);
    chk("tx status", {14'h0, exp}, {14'h0, st});
    txLevel = (exp == ST_OK && fn == FN_TX_LOAD) ? txLevel + int'(c) : 0;
    if (exp != ST_OK) purgeExp++;
    else if (fn == FN_TX_SEND) sendExp++;
    rd(REG_TX_LEVEL, v);
    chk("tx level", 18'(txLevel), {2'h0, v});
    chk("tx words left", 18'h0, 18'(txExp.size()));
    chk("tx purges", 18'(purgeExp), 18'(txPurges));
    chk("tx sends", 18'(sendExp), 18'(txSends));
  endtask
  function automatic logic [15:0] rev(input logic [15:0] x);
    for (int i = 0; i < 16; i++) rev[i] = x[15 - i];
  endfunction
  task automatic frame(input logic [10:0] nb, input logic lost, input logic align);
    logic [15:0] b;
    logic [15:0] w[$];
    int nw, n;
    b = rxBufs.pop_front();
    nw = (int'(nb) + 1) / 2;
    for (int i = 0; i < nw; i++) w.push_back(16'($random(seed)));
    @(posedge clk);
    rxLost <= lost;
    rxLen <= nb;
    rxCrcErr <= !align;
    rxAlignErr <= align;
    @(posedge clk);
    rxLost <= 1'b0;
    for (int i = 0; i < nw; i++) begin
      rxValid <= 1'b1;
      rxData <= w[i];
      rxLast <= (i == nw - 1);
      rxCrcWord <= (i >= nw - 2);
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (rxTake !== 1'b1 && n < 300);
    end
    rxValid <= 1'b0;
    repeat (30) @(posedge clk);
    chk("rx status", {15'h0, lost, align, !align}, {2'h0, MEM.mem[b[12:1]]});
    chk("rx length", {7'h0, nb}, {2'h0, MEM.mem[b[12:1] + 1]});
    for (int i = 0; i < nw; i++)
      chk("rx word", {2'h0, (i >= nw - 2) ? rev(w[i]) : w[i]},
        {2'h0, MEM.mem[b[12:1] + 2 + i]});
  endtask
  // ==========================================
  // monitors and watchdog
  always @(posedge clk) begin
    cyc++;
    if (txSend === 1'b1) txSends++;
    if (txPurge === 1'b1) txPurges++;
    if (txValid === 1'b1) begin
      if (txExp.size() == 0) chk("tx word count", 18'h0, 18'h1);
      else chk("tx word", {2'h0, txExp.pop_front()}, {2'h0, txData});
    end
    if (cyc == 80000) begin
      nErrors++;
      $display("Error watchdog expected 0 seen %0d", cyc);
      giveVerdict;
    end
  end

  initial begin
    logic [3:0] st;
    logic [15:0] v;
    logic [15:0] cb[16];
    {regWr, regRd, collWr, rxValid, rxLast, rxCrcWord, rxCrcErr, rxAlignErr, rxLost} = '0;
    {regAddr, regWdata, collBits, rxData, collCount, collIdx, rxLen, lat} = '0;
    rstn = 1'b0;
    for (int i = 0; i < 4096; i++) MEM.mem[i] = 16'($random(seed));
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    rd(3'h1, v);
    chk("unmapped read", 18'h0, {2'h0, v});
    for (logic [5:0] f = FN_ILL_LO; f <= FN_RSV_HI; f++) begin
      // supply code would queue a stray buffer
      if (f == FN_RXQ_SUPPLY) continue;
      cmd(f, 2'b01, 16'h0000, 16'h0000, st);
      if (f <= FN_ILL_HI) chk("illegal status", 18'h2, {14'h0, st});
    end
    $display("test reserved codes done");
    collCount <= 5'h10;
    for (int i = 0; i < 16; i++) begin
      cb[i] = 16'($random(seed));
      @(posedge clk);
      collWr <= 1'b1;
      collIdx <= 4'(i);
      collBits <= cb[i];
    end
    @(posedge clk);
    collWr <= 1'b0;
    cmd(FN_COLL_REPORT, 2'b01, 16'h0200, 16'h0024, st);
    chk("coll status", 18'h0, {14'h0, st});
    chk("coll length", 18'h20, {2'h0, MEM.mem[256]});
    for (int i = 0; i < 16; i++)
      chk("coll entry", {2'h0, cb[i] & COLL_RES_MASK}, {2'h0, MEM.mem[257 + i]});
    cmd(FN_COLL_REPORT, 2'b10, 16'h0200, 16'h0024, st);
    chk("coll fault", 18'hF, {14'h0, st});
    for (int i = 0; i < 5; i++) MEM.mem[384 + i] = 16'hFFFF;
    cmd(FN_MAINT, 2'b01, 16'h0300, 16'h0008, st);
    chk("maint status", 18'h0, {14'h0, st});
    for (int i = 0; i < 5; i++)
      chk("maint word", (i < 4) ? 18'h0 : 18'hFFFF, {2'h0, MEM.mem[384 + i]});
    $display("test collision and maintenance done");
    txcmd(FN_TX_LOAD, 16'h0008);
    txcmd(FN_TX_LOAD, 16'h05DD);
    txcmd(FN_TX_LOAD, 16'h05E4);
    txcmd(FN_TX_SEND, 16'h0002);
    txcmd(FN_TX_SEND, 16'h0006);
    cmd(FN_TX_LOAD, 2'b10, TXB, 16'h0004, st);
    chk("tx fault", 18'hF, {14'h0, st});
    $display("test transmit done");
    cmd(FN_RXQ_SUPPLY, 2'b10, 16'h0400, 16'h00C8, st);
    chk("rxq fault", 18'hF, {14'h0, st});
    for (int i = 0; i < 2; i++) begin
      cmd(FN_RXQ_SUPPLY, 2'b01, 16'h0400 + 16'(i * 256), 16'h00C8, st);
      chk("rxq status", 18'h0, {14'h0, st});
      rxBufs.push_back(16'h0400 + 16'(i * 256));
    end
    frame(11'h040, 1'b1, 1'b0);
    frame(11'h041, 1'b0, 1'b1);
    // nine adjacent 8-byte buffers, chained by one frame
    for (int i = 0; i < 9; i++) begin
      cmd(FN_RXQ_SUPPLY, 2'b01, 16'h0600 + 16'(i * 8), 16'h0008, st);
      chk("rxq chain status", 18'h0, {14'h0, st});
    end
    rxBufs.push_back(16'h0600);
    frame(11'h040, 1'b0, 1'b0);
    $display("test receive done");
    giveVerdict;
  end
endmodule
